// ### core/tft_sync_display_timing.sv
// TFT panel synchronous timing generator with an AHB-Lite register slave
//
// How it works
// - Drive panel clock, line sync, frame sync, data-valid enable and a pixel bus.
// - Every control is timed from a local start point by offset, rise and fall.
// - Each panel clock access lasts a whole number of base clock periods.
// - Pixel data launches exactly at the local start point, no shift.
// - Pixel bus is output only toward the panel.
// - Data holds steady around the capturing panel clock edge; clock runs continuously.
// - Line sync starts each line; frame sync is held until a line sync it overlaps has ended.
// - Data-valid marks real pixel data, its edges trailing the data launch by valid_enable_delay half steps.
// - Data-valid pin may instead serve as a software-driven general control pin.
// - All horizontal and vertical timing values come from software registers.
// - A pixel spans a programmable count of panel clocks, one or more.
// - Line counter counts total line length in panel clocks, blanking included.
// - Line sync width is programmed in half base clock steps.
// - Line is leading blank, active width, then the rest as trailing blank.
// - Frame counter counts total lines; frame syncs recur at that spacing.
// - Frame sync width is programmed in half base clock steps.
// - Frame is leading blank lines, active lines, then trailing blank lines.
// - Panel clock edges are offset from the start point in half steps.
// - Frame sync edges are offset from their start point in half steps.
// - Line sync edges are offset from their start point in half steps.
// - Data-valid edges are offset in half steps from the data launch point.
// - Each generator toggles at programmed rise and fall counts, half-step resolved.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

module tft_sync_display_timing (
  // System
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  // Timing base clock from outside
  input  wire logic        TBCLK_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Pixel source
  input  wire logic [23:0] PIX_DATA_I,
  output logic             PIX_REQ_O,
  // Panel
  output logic             PCLK_O,
  output logic             LSYNC_O,
  output logic             FSYNC_O,
  output logic             DVE_O,
  output logic      [23:0] PIX_DATA_O
);

  // ==========================================================================
  // Register bus
  tft_timing_pkg::cfg_t cfg_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_q;
  logic [15:0] x_q;
  logic [15:0] y_q;
  logic        take;

  // Zero wait states; stall while frozen so no access is lost
  assign HREADYOUT_O = CE_I;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_q;
  assign take        = HSEL_I && HREADY_I && HTRANS_I == tft_timing_pkg::HTRANS_NONSEQ;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wr_pend_q <= 1'b0;
    end else if (CE_I) begin
      wr_pend_q <= take && HWRITE_I;
    end
  end

  // Address kept for the data phase of a write
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wr_addr_q <= 8'h00;
    end else if (CE_I) begin
      wr_addr_q <= HADDR_I[7:0];
    end
  end

  // Software owns every timing value
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cfg_q <= tft_timing_pkg::CFG_RESET;
    end else if (CE_I && wr_pend_q) begin
      unique case (wr_addr_q)
        tft_timing_pkg::A_CTRL: begin
          cfg_q.ctrl <= HWDATA_I[tft_timing_pkg::CTRL_W-1:0];
        end
        tft_timing_pkg::A_CLK: begin
          cfg_q.period    <= HWDATA_I[tft_timing_pkg::F_PERIOD +: 8];
          cfg_q.clk_up    <= HWDATA_I[tft_timing_pkg::F_UP +: 8];
          cfg_q.clk_down  <= HWDATA_I[tft_timing_pkg::F_DOWN +: 8];
          cfg_q.per_pixel <= HWDATA_I[tft_timing_pkg::F_PERPIX +: 4];
        end
        tft_timing_pkg::A_HTOTAL: begin
          cfg_q.h_total <= HWDATA_I[15:0];
        end
        tft_timing_pkg::A_HBLANK: begin
          cfg_q.leading_h_blank <= HWDATA_I[15:0];
          cfg_q.active_width    <= HWDATA_I[tft_timing_pkg::F_HI +: 16];
        end
        tft_timing_pkg::A_HSYNC: begin
          cfg_q.hs_offset <= HWDATA_I[15:0];
          cfg_q.hs_width  <= HWDATA_I[tft_timing_pkg::F_HI +: 16];
        end
        tft_timing_pkg::A_VTOTAL: begin
          cfg_q.v_total <= HWDATA_I[15:0];
        end
        tft_timing_pkg::A_VBLANK: begin
          cfg_q.leading_v_blank <= HWDATA_I[15:0];
          cfg_q.active_height   <= HWDATA_I[tft_timing_pkg::F_HI +: 16];
        end
        tft_timing_pkg::A_VSOFF: begin
          cfg_q.vs_offset <= HWDATA_I[15:0];
        end
        tft_timing_pkg::A_VSWID: begin
          cfg_q.vs_width <= HWDATA_I[23:0];
        end
        tft_timing_pkg::A_DVE: begin
          cfg_q.valid_enable_delay <= HWDATA_I[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data sampled in the address phase, shown in the data phase
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_q <= 32'h00000000;
    end else if (CE_I && take && !HWRITE_I) begin
      unique case (HADDR_I[7:0])
        tft_timing_pkg::A_CTRL:   rdata_q <= {25'h0000000, cfg_q.ctrl};
        tft_timing_pkg::A_CLK:    rdata_q <= {4'h0, cfg_q.per_pixel, cfg_q.clk_down, cfg_q.clk_up, cfg_q.period};
        tft_timing_pkg::A_HTOTAL: rdata_q <= {16'h0000, cfg_q.h_total};
        tft_timing_pkg::A_HBLANK: rdata_q <= {cfg_q.active_width, cfg_q.leading_h_blank};
        tft_timing_pkg::A_HSYNC:  rdata_q <= {cfg_q.hs_width, cfg_q.hs_offset};
        tft_timing_pkg::A_VTOTAL: rdata_q <= {16'h0000, cfg_q.v_total};
        tft_timing_pkg::A_VBLANK: rdata_q <= {cfg_q.active_height, cfg_q.leading_v_blank};
        tft_timing_pkg::A_VSOFF:  rdata_q <= {16'h0000, cfg_q.vs_offset};
        tft_timing_pkg::A_VSWID:  rdata_q <= {8'h00, cfg_q.vs_width};
        tft_timing_pkg::A_DVE:    rdata_q <= {24'h000000, cfg_q.valid_enable_delay};
        tft_timing_pkg::A_STATUS: rdata_q <= {y_q, x_q};
        default:                  rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Base clock sampling
  logic tb_s1_q;
  logic tb_s2_q;
  logic tb_s3_q;
  logic tb_lvl_q;
  logic half_tick;
  logic run;

  // Level accepted only once two later stages agree
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tb_s1_q  <= 1'b0;
      tb_s2_q  <= 1'b0;
      tb_s3_q  <= 1'b0;
      tb_lvl_q <= 1'b0;
    end else if (CE_I) begin
      tb_s1_q <= TBCLK_I;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
      if (tb_s2_q == tb_s3_q) begin
        tb_lvl_q <= tb_s3_q;
      end
    end
  end

  // Both base clock edges count, giving half-period resolution
  assign run       = cfg_q.ctrl[tft_timing_pkg::C_ENABLE];
  assign half_tick = run && tb_s2_q == tb_s3_q && tb_s3_q != tb_lvl_q;

  // ==========================================================================
  // Access, pixel, line and frame counters
  logic [8:0]  hc_q;
  logic [8:0]  hc_n;
  logic [8:0]  period_half;
  logic        hc_wrap;
  logic [3:0]  comp_q;
  logic        comp_wrap;
  logic        launch;
  logic        x_wrap;
  logic        y_wrap;
  logic [15:0] x_n;
  logic [15:0] y_n;
  logic [23:0] lh_q;
  logic [31:0] fh_q;
  logic        line_start;
  logic        frame_start;
  logic        start_q;
  logic [23:0] lh_n;
  logic [31:0] fh_n;

  assign period_half = {cfg_q.period, 1'b0};
  assign hc_wrap     = start_q || hc_q == period_half - 9'h001;
  assign hc_n        = hc_wrap ? 9'h000 : hc_q + 9'h001;
  assign comp_wrap   = start_q || comp_q + 4'h1 >= cfg_q.per_pixel;
  assign x_wrap      = start_q || x_q + 16'h0001 >= cfg_q.h_total;
  assign y_wrap      = start_q || y_q + 16'h0001 >= cfg_q.v_total;
  assign x_n         = x_wrap ? 16'h0000 : x_q + 16'h0001;
  assign y_n         = x_wrap ? (y_wrap ? 16'h0000 : y_q + 16'h0001) : y_q;
  assign line_start  = half_tick && hc_wrap && x_wrap;
  assign frame_start = line_start && y_wrap;
  // Local start point of a new pixel
  assign launch      = half_tick && hc_wrap && comp_wrap;

  // First half step after enabling is a full local start point, so frame one is whole
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      start_q <= 1'b1;
    end else if (CE_I && half_tick) begin
      start_q <= 1'b0;
    end
  end

  // Access position in half steps
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      hc_q <= 9'h000;
    end else if (CE_I && half_tick) begin
      hc_q <= hc_n;
    end
  end

  // Component within the current pixel
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      comp_q <= 4'h0;
    end else if (CE_I && half_tick && hc_wrap) begin
      comp_q <= comp_wrap ? 4'h0 : comp_q + 4'h1;
    end
  end

  // Panel clocks within the line
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      x_q <= 16'h0000;
    end else if (CE_I && half_tick && hc_wrap) begin
      x_q <= x_n;
    end
  end

  // Lines within the frame
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      y_q <= 16'h0000;
    end else if (CE_I && half_tick && hc_wrap) begin
      y_q <= y_n;
    end
  end

  // Position of the step being entered, so offset zero meets the launch itself
  assign lh_n = line_start ? 24'h000000 : lh_q + 24'h000001;
  assign fh_n = frame_start ? 32'h00000000 : fh_q + 32'h00000001;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      lh_q <= 24'h000000;
    end else if (CE_I && half_tick) begin
      lh_q <= lh_n;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      fh_q <= 32'h00000000;
    end else if (CE_I && half_tick) begin
      fh_q <= fh_n;
    end
  end

  // ==========================================================================
  // Control generators
  logic        pclk_act;
  logic        hs_act;
  logic        vs_act;
  logic [24:0] hs_end;
  logic [32:0] vs_end;
  logic        in_region;
  logic        region_q;
  logic        region_d;
  logic        vs_lvl_q;

  // Fall edge must sit away from the launch so data is steady when captured
  assign pclk_act = hc_n >= {1'b0, cfg_q.clk_up} && hc_n < {1'b0, cfg_q.clk_down};
  assign hs_end   = {9'h000, cfg_q.hs_offset} + {9'h000, cfg_q.hs_width};
  assign hs_act   = {1'b0, lh_n} >= {9'h000, cfg_q.hs_offset} && {1'b0, lh_n} < hs_end;
  assign vs_end   = {17'h00000, cfg_q.vs_offset} + {9'h000, cfg_q.vs_width};
  assign vs_act   = {1'b0, fh_n} >= {17'h00000, cfg_q.vs_offset} && {1'b0, fh_n} < vs_end;
  assign in_region = x_n >= cfg_q.leading_h_blank
                  && {1'b0, x_n} < {1'b0, cfg_q.leading_h_blank} + {1'b0, cfg_q.active_width}
                  && y_n >= cfg_q.leading_v_blank
                  && {1'b0, y_n} < {1'b0, cfg_q.leading_v_blank} + {1'b0, cfg_q.active_height};
  assign region_d = launch ? in_region : region_q;

  // Region flag of the latest launched pixel
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      region_q <= 1'b0;
    end else if (CE_I && half_tick) begin
      region_q <= region_d;
    end
  end

  // Frame sync held until the line sync it covers has ended
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !run) begin
      vs_lvl_q <= 1'b0;
    end else if (CE_I && half_tick) begin
      vs_lvl_q <= vs_act || (vs_lvl_q && hs_act);
    end
  end

  // ==========================================================================
  // Panel outputs
  tft_timing_pkg::panel_t pan_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      pan_q <= '0;
    end else if (CE_I) begin
      if (!run) begin
        pan_q.pclk  <= cfg_q.ctrl[tft_timing_pkg::C_CLK_POL];
        pan_q.lsync <= cfg_q.ctrl[tft_timing_pkg::C_HS_POL];
        pan_q.fsync <= cfg_q.ctrl[tft_timing_pkg::C_VS_POL];
        pan_q.dve   <= cfg_q.ctrl[tft_timing_pkg::C_DVE_GP] ? cfg_q.ctrl[tft_timing_pkg::C_GP_LVL]
                                                            : cfg_q.ctrl[tft_timing_pkg::C_DVE_POL];
        pan_q.data  <= 24'h000000;
      end else begin
        if (half_tick) begin
          pan_q.pclk  <= pclk_act ^ cfg_q.ctrl[tft_timing_pkg::C_CLK_POL];
          pan_q.lsync <= hs_act ^ cfg_q.ctrl[tft_timing_pkg::C_HS_POL];
          pan_q.fsync <= (vs_act || (vs_lvl_q && hs_act)) ^ cfg_q.ctrl[tft_timing_pkg::C_VS_POL];
        end
        if (cfg_q.ctrl[tft_timing_pkg::C_DVE_GP]) begin
          pan_q.dve <= cfg_q.ctrl[tft_timing_pkg::C_GP_LVL];
        end else if (half_tick && hc_n == {1'b0, cfg_q.valid_enable_delay}) begin
          pan_q.dve <= region_d ^ cfg_q.ctrl[tft_timing_pkg::C_DVE_POL];
        end
        if (launch) begin
          // Blank pixels carry zero so the bus never shows stale data
          pan_q.data <= in_region ? PIX_DATA_I : 24'h000000;
        end
      end
    end
  end

  // Pixel consumed in the launch cycle itself
  assign PIX_REQ_O  = CE_I && launch && in_region;
  assign PCLK_O     = pan_q.pclk;
  assign LSYNC_O    = pan_q.lsync;
  assign FSYNC_O    = pan_q.fsync;
  assign DVE_O      = pan_q.dve;
  assign PIX_DATA_O = pan_q.data;

endmodule

// ### core/tft_timing_pkg.sv
// Package: register map, field layout and reset values of the TFT timing block
package tft_timing_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CLK    = 8'h04;
  localparam logic [7:0] A_HTOTAL = 8'h08;
  localparam logic [7:0] A_HBLANK = 8'h0C;
  localparam logic [7:0] A_HSYNC  = 8'h10;
  localparam logic [7:0] A_VTOTAL = 8'h14;
  localparam logic [7:0] A_VBLANK = 8'h18;
  localparam logic [7:0] A_VSOFF  = 8'h1C;
  localparam logic [7:0] A_VSWID  = 8'h20;
  localparam logic [7:0] A_DVE    = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;

  // ==========================================================================
  // Control register bit positions
  localparam int C_ENABLE  = 0;
  localparam int C_CLK_POL = 1;
  localparam int C_HS_POL  = 2;
  localparam int C_VS_POL  = 3;
  localparam int C_DVE_POL = 4;
  localparam int C_DVE_GP  = 5;
  localparam int C_GP_LVL  = 6;
  localparam int CTRL_W    = 7;

  // Clock register field positions, then the upper-half field of the paired registers
  localparam int F_PERIOD = 0;
  localparam int F_UP     = 8;
  localparam int F_DOWN   = 16;
  localparam int F_PERPIX = 24;
  localparam int F_HI     = 16;

  // ==========================================================================
  // Reset values
  localparam logic [CTRL_W-1:0] R_CTRL   = 7'h00;
  localparam logic [7:0]        R_PERIOD = 8'h02;
  localparam logic [7:0]        R_UP     = 8'h00;
  localparam logic [7:0]        R_DOWN   = 8'h02;
  localparam logic [3:0]        R_PERPIX = 4'h1;
  localparam logic [15:0]       R_HTOTAL = 16'h0020;
  localparam logic [15:0]       R_HBL    = 16'h0004;
  localparam logic [15:0]       R_AW     = 16'h0010;
  localparam logic [15:0]       R_HSOFF  = 16'h0000;
  localparam logic [15:0]       R_HSW    = 16'h0004;
  localparam logic [15:0]       R_VTOTAL = 16'h0010;
  localparam logic [15:0]       R_VBL    = 16'h0002;
  localparam logic [15:0]       R_AH     = 16'h0008;
  localparam logic [15:0]       R_VSOFF  = 16'h0000;
  localparam logic [23:0]       R_VSW    = 24'h000100;
  localparam logic [7:0]        R_DVE    = 8'h00;

  // ==========================================================================
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // ==========================================================================
  // Timing configuration carried as one group
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [7:0]        period;
    logic [7:0]        clk_up;
    logic [7:0]        clk_down;
    logic [3:0]        per_pixel;
    logic [15:0]       h_total;
    logic [15:0]       leading_h_blank;
    logic [15:0]       active_width;
    logic [15:0]       hs_offset;
    logic [15:0]       hs_width;
    logic [15:0]       v_total;
    logic [15:0]       leading_v_blank;
    logic [15:0]       active_height;
    logic [15:0]       vs_offset;
    logic [23:0]       vs_width;
    logic [7:0]        valid_enable_delay;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    ctrl: R_CTRL, period: R_PERIOD, clk_up: R_UP, clk_down: R_DOWN, per_pixel: R_PERPIX,
    h_total: R_HTOTAL, leading_h_blank: R_HBL, active_width: R_AW, hs_offset: R_HSOFF,
    hs_width: R_HSW, v_total: R_VTOTAL, leading_v_blank: R_VBL, active_height: R_AH,
    vs_offset: R_VSOFF, vs_width: R_VSW, valid_enable_delay: R_DVE};

  // Panel-side output group
  typedef struct packed {
    logic        pclk;
    logic        lsync;
    logic        fsync;
    logic        dve;
    logic [23:0] data;
  } panel_t;

endpackage

// ### tb/tft_timing_assertions.sv
// Checker for the TFT timing block ports
`timescale 1ns/1ps

module tft_timing_checker (
  // System
  input wire logic        CLK_SYS_I,
  input wire logic        RST_I,
  input wire logic        CE_I,
  // Bus
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  // Pixels and panel
  input wire logic [23:0] PIX_DATA_I,
  input wire logic        PIX_REQ_O,
  input wire logic        PCLK_O,
  input wire logic        LSYNC_O,
  input wire logic        FSYNC_O,
  input wire logic        DVE_O,
  input wire logic [23:0] PIX_DATA_O
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic rd_take;
  assign rd_take = HSEL_I && HREADY_I && HTRANS_I == tft_timing_pkg::HTRANS_NONSEQ && !HWRITE_I && CE_I;

  // ==========================================================================
  // Properties
  a_launch_data: assert property (PIX_REQ_O && CE_I |=> PIX_DATA_O == $past(PIX_DATA_I))
    else $error("pixel bus not launched from source");
  a_req_gap: assert property (PIX_REQ_O |=> !PIX_REQ_O [*3])
    else $error("pixel launches too close");
  a_data_cause: assert property ($changed(PIX_DATA_O) && PIX_DATA_O != 24'h0 |-> $past(PIX_REQ_O))
    else $error("pixel data without launch");
  a_reset_quiet: assert property ($fell(RST_I) |-> {PCLK_O, LSYNC_O, FSYNC_O, DVE_O, PIX_DATA_O} == 28'h0)
    else $error("outputs not quiet after reset");
  a_ready_ce: assert property (HREADYOUT_O == CE_I)
    else $error("ready does not follow enable");
  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("response not okay");
  a_unmapped_zero: assert property (rd_take && HADDR_I[7:0] > tft_timing_pkg::A_STATUS |=> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd_take |=> $stable(HRDATA_O))
    else $error("read data moved without read");
  a_ce_freeze: assert property (!CE_I |=> $stable({PCLK_O, LSYNC_O, FSYNC_O, DVE_O, PIX_DATA_O}))
    else $error("panel outputs moved while frozen");
endmodule

bind tft_sync_display_timing tft_timing_checker tft_timing_checker_i (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .PIX_DATA_I(PIX_DATA_I), .PIX_REQ_O(PIX_REQ_O),
  .PCLK_O(PCLK_O), .LSYNC_O(LSYNC_O), .FSYNC_O(FSYNC_O), .DVE_O(DVE_O), .PIX_DATA_O(PIX_DATA_O));

// ### tb/tft_panel_model.sv
// Panel model: captures pixels and counts lines per frame
`timescale 1ns/1ps

module tft_panel_model (
  // Panel pins
  input  wire logic        pclk_i,
  input  wire logic        lsync_i,
  input  wire logic        fsync_i,
  input  wire logic        dve_i,
  input  wire logic [23:0] data_i,
  // Counts of the last whole frame, and a running count of out-of-order pixels
  output int               frame_pix_o,
  output int               frame_lines_o,
  output int               bad_o
);
  int          pix_n = 0;
  int          line_n = 0;
  logic [23:0] last;
  logic        have = 1'b0;
  initial begin
    bad_o = 0;
    frame_pix_o = 0;
    frame_lines_o = 0;
  end
  // ==========================================================================
  // Capture on the falling clock, only while valid
  always @(negedge pclk_i) begin
    if (dve_i === 1'b1) begin
      if (have && data_i !== last + 24'h1) bad_o = bad_o + 1;
      last = data_i;
      have = 1'b1;
      pix_n = pix_n + 1;
    end
  end
  // Falling edge avoids a race with the frame start
  always @(negedge lsync_i) line_n = line_n + 1;
  always @(posedge fsync_i) begin
    frame_pix_o = pix_n;
    frame_lines_o = line_n;
    pix_n = 0;
    line_n = 0;
    have = 1'b0;
  end
endmodule

// ### tb/test_tft_sync_display_timing.sv
// Testbench for the TFT timing block
`timescale 1ns/1ps

module test_tft_sync_display_timing;
  logic        clk, rst, ce, tbclk, hsel, hwrite, hready, hresp, pix_req, pclk, lsync, fsync, dve;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [23:0] pix_in, pix_out;
  logic [3:0]  mon;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          fpix, flines, bad;
  assign mon = {pclk, dve, fsync, lsync};

  tft_sync_display_timing tft_sync_display_timing_i (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .TBCLK_I(tbclk), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(tft_timing_pkg::HSIZE_WORD), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .PIX_DATA_I(pix_in),
    .PIX_REQ_O(pix_req), .PCLK_O(pclk), .LSYNC_O(lsync), .FSYNC_O(fsync), .DVE_O(dve), .PIX_DATA_O(pix_out));
  tft_panel_model tft_panel_model_i (
    .pclk_i(pclk), .lsync_i(lsync), .fsync_i(fsync), .dve_i(dve), .data_i(pix_out),
    .frame_pix_o(fpix), .frame_lines_o(flines), .bad_o(bad));

  // ==========================================================================
  // Clocks and pixel source
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Odd start keeps the base clock unrelated in phase
  initial begin
    tbclk = 1'b0;
    #7;
    forever #160 tbclk = ~tbclk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (pix_req === 1'b1) pix_in <= pix_in + 24'h1;

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= tft_timing_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
        fails++;
        complete_run();
      end
      if (ph == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask
  task automatic edge_at(input int b, input logic lvl, output int t);
    logic prev;
    for (int n = 0; n < 4000; n++) begin
      prev = mon[b];
      @(negedge clk);
      if (mon[b] === lvl && prev !== lvl) begin
        t = cyc;
        return;
      end
    end
    fails++;
    complete_run();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0]  a [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30};
    logic [31:0] e [8] = '{32'h0, 32'h01020002, 32'h20, 32'h00100004, 32'h00040000, 32'h00080002, 32'h100, 32'h0};
    bus(1'b1, 8'h30, 32'hFFFFFFFF);
    bus(1'b1, tft_timing_pkg::A_STATUS, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk("reset value", rd, e[i]);
    end
    bus(1'b0, tft_timing_pkg::A_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    chk("idle outputs", {4'h0, mon, pix_out}, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    chk("stall", {31'h0, hready}, 32'h0);
    repeat (3) @(posedge clk);
    ce <= 1'b1;
  endtask
  task automatic t_pol();
    logic [31:0] c [3] = '{32'h1E, 32'h60, 32'h20};
    logic [31:0] e [3] = '{32'hF, 32'h4, 32'h0};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, tft_timing_pkg::A_CTRL, c[i]);
      repeat (3) @(negedge clk);
      chk("inactive levels", {28'h0, mon}, e[i]);
    end
  endtask
  task automatic t_timing(input int dly);
    int f0, a, b;
    bus(1'b1, tft_timing_pkg::A_CLK, 32'h01020002);
    bus(1'b1, tft_timing_pkg::A_HTOTAL, 32'd12);
    bus(1'b1, tft_timing_pkg::A_HBLANK, 32'h00060002);
    bus(1'b1, tft_timing_pkg::A_HSYNC, 32'h00040000);
    bus(1'b1, tft_timing_pkg::A_VTOTAL, 32'd6);
    bus(1'b1, tft_timing_pkg::A_VBLANK, 32'h00030001);
    bus(1'b1, tft_timing_pkg::A_VSWID, 32'd2);
    bus(1'b1, tft_timing_pkg::A_DVE, 32'(dly));
    bus(1'b1, tft_timing_pkg::A_CTRL, 32'h1);
    edge_at(1, 1'b1, f0);
    edge_at(1, 1'b0, a);
    chk("frame sync width", 32'(a - f0), 32'd16);
    edge_at(2, 1'b1, b);
    chk("first valid", 32'(b - f0), 32'(224 + 4 * dly));
    edge_at(2, 1'b0, a);
    chk("valid width", 32'(a - b), 32'd96);
    edge_at(3, 1'b1, a);
    edge_at(3, 1'b1, b);
    chk("panel clock period", 32'(b - a), 32'd16);
    edge_at(0, 1'b1, a);
    edge_at(0, 1'b0, b);
    chk("line sync width", 32'(b - a), 32'd16);
    edge_at(0, 1'b1, b);
    chk("line period", 32'(b - a), 32'd192);
    edge_at(1, 1'b1, b);
    chk("frame period", 32'(b - f0), 32'd1152);
    chk("pixels per frame", 32'(fpix), 32'd18);
    chk("lines per frame", 32'(flines), 32'd6);
    @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pix_in = 24'h000001;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pol();
    t_timing(0);
    t_timing(1);
    chk("panel data order", 32'(bad), 32'h0);
    complete_run();
  end
endmodule
